// ==== smc_strap_clkout.v ====
// strap capture, mode register and sensor clock output on the shared strap pin
//
// Behaviour
// - clock out in every mode except internal oscillator
// - out = rate * num / (divider * den) for num/den up to one half; above that it falls lower
// - digital PLL, accumulator, jitter one tick
// - four modes, default from mode strap
// - mode readable and writable via registers
// - code 0 sync, code 2 external
// - code 3 internal oscillator, 5 parallel
// - parallel mode forbids low-frequency 12-bit raw
// - shared pin strap first, then clock
// - control bus answers one of two addresses
// - levels 1/3 0x18, 2/4 0x19; voltage
// - mode field read-only unless override bit
// - mode latched on power enable rising
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"

module smc_strap_clkout (
    input  wire        clk_sys,                // 125 MHz system clock
    input  wire        rstn,                   // async reset, active low
    input  wire        chip_power_enable_pin,  // power-down pin, high = run
    input  wire [2:0]  mode_strap_code,        // quantised mode strap
    input  wire [1:0]  address_strap_input,    // quantised address strap level 1..4 as 0..3
    input  wire        reg_wr,                 // register write strobe
    input  wire [7:0]  reg_addr,               // register offset
    input  wire [7:0]  reg_wdata,              // write data
    output reg  [7:0]  reg_rdata_q,            // read data, registered
    output reg  [2:0]  mode_q,                 // active mode code
    output reg  [6:0]  dev_addr_q,             // control bus device address
    output reg         io_3v3_q,               // 1 = 3.3 V I/O, 0 = 1.8 V
    output reg         ten_bit_raw_ok_q,       // 10-bit raw usable
    output reg         high_freq_12bit_raw_ok_q, // high-frequency 12-bit raw usable
    output reg         low_freq_12bit_raw_ok_q,  // low-frequency 12-bit raw usable
    output reg         ref_from_back_q,        // forward ref from deserializer
    output reg         ref_from_ext_q,         // forward ref from external_ref_clock_input
    output reg         ref_from_always_on_q,   // forward ref from always_on_oscillator
    output reg         internal_osc_rate_select_q, // oscillator rate select
    output reg         clkout_o_q,             // shared pin output level
    output reg         clkout_oe_n_q           // shared pin output enable, low = drive
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    localparam ST_OFF    = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_RUN    = 2'h2;

    reg  [1:0]  st_q;
    reg         pdb_q;                         // previous power enable level
    reg         ovr_q;                         // mode override enable
    reg  [7:0]  ratio_a_q;                     // [7:2] numerator, [1:0] divider select
    reg  [7:0]  ratio_b_q;                     // denominator
    reg  [7:0]  osc_cfg_q;                     // oscillator rate and clock-out enable
    wire        pdb_rise;
    wire        mode_ok;
    wire        clk_allowed;
    wire        div_clk;
    wire [7:0]  num_w;
    wire [1:0]  div_w;

    assign pdb_rise = chip_power_enable_pin & ~pdb_q;

    // only the four documented codes are legal modes
    assign mode_ok = (mode_strap_code == `SMC_MODE_SYNC) || (mode_strap_code == `SMC_MODE_NSYNC_EXT) ||
                     (mode_strap_code == `SMC_MODE_NSYNC_INT) || (mode_strap_code == `SMC_MODE_PAR_COMPAT);

    // internal oscillator mode never drives the clock
    assign clk_allowed = (st_q == ST_RUN) && (mode_q != `SMC_MODE_NSYNC_INT) &&
                         osc_cfg_q[`SMC_CLKOUT_EN_BIT];

    // ratio a: [7:2] numerator, [1:0] divider select; ratio b: denominator
    assign num_w = {2'h0, ratio_a_q[7:2]};
    assign div_w = ratio_a_q[1:0];

    // ---------------------------------------------------------------
    // power sequencing and strap capture
    // ---------------------------------------------------------------
    // straps are read one cycle after the power enable edge, never under reset,
    // and held until reset, the next power-up or an override write of the mode
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q       <= ST_OFF;
            pdb_q      <= 1'b1;                // a pin already high at release is no power-up edge
            mode_q     <= `SMC_MODE_SYNC;
            dev_addr_q <= `SMC_ADDR_A;
            io_3v3_q   <= 1'b0;
        end
        else
        begin
            pdb_q <= chip_power_enable_pin;
            case (st_q)
                ST_OFF:
                begin
                    if (pdb_rise)
                        st_q <= ST_SAMPLE;
                end
                ST_SAMPLE:
                begin
                    // pin is a strap input here, driver stays off
                    if (mode_ok)
                        mode_q <= mode_strap_code;
                    else
                        mode_q <= `SMC_MODE_SYNC;
                    // levels 1/3 and 2/4 share an address
                    dev_addr_q <= address_strap_input[0] ? `SMC_ADDR_B : `SMC_ADDR_A;
                    io_3v3_q   <= address_strap_input[1];
                    st_q       <= ST_RUN;                   // pin switches to clock
                end
                ST_RUN:
                begin
                    if (!chip_power_enable_pin)
                        st_q <= ST_OFF;
                    else if (reg_wr && reg_addr == `SMC_OFS_MODE_SEL && ovr_q)
                        mode_q <= reg_wdata[`SMC_MODE_MSB:0];  // writable under override
                end
                default:
                    st_q <= ST_OFF;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // writable registers
    // ---------------------------------------------------------------
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ovr_q     <= 1'b0;
            ratio_a_q <= `SMC_RST_RATIO_A;
            ratio_b_q <= `SMC_RST_RATIO_B;
            osc_cfg_q <= `SMC_RST_OSC_CFG;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `SMC_OFS_MODE_SEL: ovr_q     <= reg_wdata[`SMC_MODE_OVR_BIT];
                `SMC_OFS_OSC_CFG:  osc_cfg_q <= reg_wdata;
                `SMC_OFS_RATIO_A:  ratio_a_q <= reg_wdata;
                `SMC_OFS_RATIO_B:  ratio_b_q <= reg_wdata;
                default:           ovr_q     <= ovr_q;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // read mux: mode field always shows live mode
    // ---------------------------------------------------------------
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            reg_rdata_q <= 8'h00;
        else
        begin
            case (reg_addr)
                `SMC_OFS_MODE_SEL: reg_rdata_q <= {3'h0, ovr_q, 1'b0, mode_q};
                `SMC_OFS_OSC_CFG:  reg_rdata_q <= osc_cfg_q;
                `SMC_OFS_RATIO_A:  reg_rdata_q <= ratio_a_q;
                `SMC_OFS_RATIO_B:  reg_rdata_q <= ratio_b_q;
                default:           reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // mode decode: reference source and raw formats
    // ---------------------------------------------------------------
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ref_from_back_q            <= 1'b1;
            ref_from_ext_q             <= 1'b0;
            ref_from_always_on_q       <= 1'b0;
            ten_bit_raw_ok_q           <= 1'b1;
            high_freq_12bit_raw_ok_q   <= 1'b1;
            low_freq_12bit_raw_ok_q    <= 1'b1;
            internal_osc_rate_select_q <= 1'b0;
        end
        else
        begin
            ref_from_back_q      <= (mode_q == `SMC_MODE_SYNC);
            ref_from_ext_q       <= (mode_q == `SMC_MODE_NSYNC_EXT) ||
                                    (mode_q == `SMC_MODE_PAR_COMPAT);
            ref_from_always_on_q <= (mode_q == `SMC_MODE_NSYNC_INT);
            ten_bit_raw_ok_q         <= 1'b1;
            high_freq_12bit_raw_ok_q <= 1'b1;
            low_freq_12bit_raw_ok_q  <= (mode_q != `SMC_MODE_PAR_COMPAT);
            internal_osc_rate_select_q <= osc_cfg_q[`SMC_OSC_SEL_BIT];
        end
    end

    // ---------------------------------------------------------------
    // clock generator; clk_sys stands in for the forward rate tap
    // ---------------------------------------------------------------
    smc_frac_div u_div (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .run     (clk_allowed),
        .div_sel (div_w),
        .num     (num_w),
        .den     (ratio_b_q),
        .clk_q   (div_clk)
    );

    // output stage registered so the pin never glitches on mode changes
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            clkout_o_q    <= 1'b0;
            clkout_oe_n_q <= 1'b1;
        end
        else
        begin
            clkout_o_q    <= clk_allowed & div_clk;
            clkout_oe_n_q <= ~clk_allowed;
        end
    end

endmodule // smc_strap_clkout
`default_nettype wire

// ==== smc_regs.vh ====
// register offsets, field positions, reset values and strap codes for the strap/clock-out block
`ifndef SMC_REGS_VH
`define SMC_REGS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SMC_OFS_MODE_SEL     8'h03
`define SMC_OFS_OSC_CFG      8'h05
`define SMC_OFS_RATIO_A      8'h06
`define SMC_OFS_RATIO_B      8'h07

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SMC_MODE_MSB         2
`define SMC_MODE_OVR_BIT     4
`define SMC_OSC_SEL_BIT      3
`define SMC_CLKOUT_EN_BIT    0

// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define SMC_MODE_SYNC        3'h0
`define SMC_MODE_NSYNC_EXT   3'h2
`define SMC_MODE_NSYNC_INT   3'h3
`define SMC_MODE_PAR_COMPAT  3'h5

// ---------------------------------------------------------------
// address strap levels and decoded addresses
// ---------------------------------------------------------------
`define SMC_IDX_LVL1         2'h0
`define SMC_IDX_LVL2         2'h1
`define SMC_IDX_LVL3         2'h2
`define SMC_IDX_LVL4         2'h3
`define SMC_ADDR_A           7'h18
`define SMC_ADDR_B           7'h19

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SMC_RST_RATIO_A      8'h10
`define SMC_RST_RATIO_B      8'h01
`define SMC_RST_OSC_CFG      8'h00
`define SMC_DIV_RST          2'h0

`endif

// ==== smc_frac_div.v ====
// fractional clock generator: accumulator based digital divider for the sensor clock
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"

module smc_frac_div (
    input  wire        clk_sys,   // link-rate derived clock
    input  wire        rstn,      // async reset, active low
    input  wire        run,       // enable clock generation
    input  wire [1:0]  div_sel,   // high-speed divider: 0=4 1=8 2=16
    input  wire [7:0]  num,       // numerator
    input  wire [7:0]  den,       // denominator
    output reg         clk_q      // generated clock level
);

    reg  [4:0]  pre_q;            // high-speed prescaler count
    reg  [9:0]  acc_q;            // phase accumulator
    wire [4:0]  pre_max;
    wire        tick;
    wire [9:0]  sum;
    wire [9:0]  lim;

    assign pre_max = (div_sel == 2'h2) ? 5'h0F : (div_sel == 2'h1) ? 5'h07 : 5'h03;
    assign tick    = (pre_q >= pre_max);   // >= so a shrunk divider never stalls the count
    assign sum     = acc_q + {1'b0, num, 1'b0};
    assign lim     = {2'h0, den};

    // ---------------------------------------------------------------
    // prescale by the divider, then add 2*num each tick modulo den;
    // each wrap toggles, so out = tick*num/den; jitter one tick when
    // den/(2*num) is not whole; num/den above one half falls below one
    // toggle per tick, as a phase of den or more costs a tick
    // ---------------------------------------------------------------
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pre_q <= 5'h00;
            acc_q <= 10'h000;
            clk_q <= 1'b0;
        end
        else if (!run || den == 8'h00 || num == 8'h00)
        begin
            pre_q <= 5'h00;
            acc_q <= 10'h000;
            clk_q <= 1'b0;
        end
        else
        begin
            pre_q <= tick ? 5'h00 : pre_q + 5'h01;
            if (tick)
            begin
                if (acc_q >= lim)
                begin
                    acc_q <= 10'h000;   // phase of den or more, left by a ratio change or by num/den above one half
                end
                else if (sum >= lim)
                begin
                    acc_q <= sum - lim;
                    clk_q <= ~clk_q;
                end
                else
                begin
                    acc_q <= sum;
                end
            end
        end
    end

endmodule // smc_frac_div
`default_nettype wire

// ==== smc_properties.sv ====
// checker: strap decode, mode and shared-pin relations of the strap/clock-out block
`timescale 1ns/1ps
`default_nettype none
module smc_strap_props (
    input wire logic       clk_sys,                    // clock
    input wire logic       rstn,                       // reset, low
    input wire logic       chip_power_enable_pin,      // power enable
    input wire logic [2:0] mode_strap_code,            // mode strap
    input wire logic [1:0] address_strap_input,        // address strap
    input wire logic       reg_wr,                     // write strobe
    input wire logic [7:0] reg_addr,                   // offset
    input wire logic [7:0] reg_wdata,                  // write data
    input wire logic [7:0] reg_rdata_q,                // read data
    input wire logic [2:0] mode_q,                     // mode
    input wire logic [6:0] dev_addr_q,                 // bus address
    input wire logic       io_3v3_q,                   // io level
    input wire logic       ten_bit_raw_ok_q,           // format ok
    input wire logic       high_freq_12bit_raw_ok_q,   // format ok
    input wire logic       low_freq_12bit_raw_ok_q,    // format ok
    input wire logic       ref_from_back_q,            // ref select
    input wire logic       ref_from_ext_q,             // ref select
    input wire logic       ref_from_always_on_q,       // ref select
    input wire logic       internal_osc_rate_select_q, // osc rate
    input wire logic       clkout_o_q,                 // pin level
    input wire logic       clkout_oe_n_q               // pin enable, low
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // output registers lag mode_q by one edge, so checks look one edge back
    oe_int_off_a : assert property ((mode_q == 3'h3) [*2] |-> clkout_oe_n_q)
        else $error("clock out driven in internal mode");
    addr_decode_a : assert property ($changed(dev_addr_q) |-> dev_addr_q == {6'h0C, $past(address_strap_input[0])})
        else $error("bus address not from strap");
    io_decode_a : assert property ($changed(io_3v3_q) |-> io_3v3_q == $past(address_strap_input[1]))
        else $error("io level not from strap");
    raw_formats_a : assert property (ten_bit_raw_ok_q && high_freq_12bit_raw_ok_q)
        else $error("supported format flagged off");
    lf12_block_a : assert property (low_freq_12bit_raw_ok_q == ($past(mode_q) != 3'h5))
        else $error("low freq format flag wrong");
    ref_aon_a : assert property ($past(mode_q) == 3'h3 |-> ref_from_always_on_q && !ref_from_back_q && !ref_from_ext_q)
        else $error("reference not internal");
    ref_sync_a : assert property ($past(mode_q) == 3'h0 |-> ref_from_back_q && !ref_from_ext_q)
        else $error("reference not recovered");
    ref_ext_a : assert property ($past(mode_q) == 3'h2 |-> ref_from_ext_q && !ref_from_back_q)
        else $error("reference not external");
    mode_cause_a : assert property ($changed(mode_q) |-> $past(reg_wr) || ($past(chip_power_enable_pin) && !$past(chip_power_enable_pin, 4)))
        else $error("mode changed without cause");
    strap_oe_off_a : assert property ($rose(chip_power_enable_pin) |-> clkout_oe_n_q [*2])
        else $error("pin driven during strap sampling");
endmodule // smc_strap_props
bind smc_strap_clkout smc_strap_props smc_strap_props_i (.*);
`default_nettype wire

// ==== smc_sensor_model.sv ====
// sensor-side model: watches the shared pin and counts clock rising edges
`timescale 1ns/1ps
`default_nettype none
module smc_sensor_model (
    input wire logic         clk_sys,       // clock
    input wire logic         clkout_o_q,    // pin level
    input wire logic         clkout_oe_n_q, // pin enable, low
    input wire logic         cnt_clr,       // clear count
    output var logic [15:0]  edge_cnt       // rising edges seen
);
    logic pad_q;
    // released pin sits at the strap divider level, read here as low
    wire logic pad = clkout_oe_n_q ? 1'b0 : clkout_o_q;
    always @(posedge clk_sys)
    begin
        pad_q <= pad;
        if (cnt_clr)
            edge_cnt <= 16'h0;
        else if (pad && !pad_q)
            edge_cnt <= edge_cnt + 16'h1;
    end
endmodule // smc_sensor_model
`default_nettype wire

// ==== tb_top.sv ====
// testbench: strap rows, mode register, clock ratio and reset of the strap/clock-out block
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.vh"
module tb_top;
    logic clk_sys = 0, rstn = 0, chip_power_enable_pin = 0, reg_wr = 0, cnt_clr = 1;
    logic [2:0] mode_strap_code = 0, mode_q;
    logic [1:0] address_strap_input = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_q;
    logic [6:0] dev_addr_q;
    logic io_3v3_q, ten_bit_raw_ok_q, high_freq_12bit_raw_ok_q, low_freq_12bit_raw_ok_q;
    logic ref_from_back_q, ref_from_ext_q, ref_from_always_on_q, internal_osc_rate_select_q;
    logic clkout_o_q, clkout_oe_n_q;
    logic [15:0] edge_cnt;
    int err_total = 0, checked = 0;
    // strap in, mode, bus address, io, pin enable, low freq format ok
    typedef struct packed {logic [2:0] st; logic [1:0] ix; logic [2:0] md; logic [6:0] ad;
        logic io; logic oe; logic lf;} smc_row_t;
    smc_row_t rows [5] = '{
        '{3'h0, 2'h0, 3'h0, 7'h18, 1'b0, 1'b0, 1'b1}, '{3'h2, 2'h1, 3'h2, 7'h19, 1'b0, 1'b0, 1'b1},
        '{3'h3, 2'h2, 3'h3, 7'h18, 1'b1, 1'b1, 1'b1}, '{3'h7, 2'h0, 3'h0, 7'h18, 1'b0, 1'b0, 1'b1},
        '{3'h5, 2'h3, 3'h5, 7'h19, 1'b1, 1'b0, 1'b0}};
    always #4 clk_sys = ~clk_sys;
    smc_strap_clkout smc_strap_clkout_i (.*);
    smc_sensor_model smc_sensor_model_i (.*);
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one-cycle write strobe, launched at a falling edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a; reg_wdata = d; reg_wr = 1;
        @(negedge clk_sys);
        reg_wr = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        @(negedge clk_sys);
        chk(reg_rdata_q, exp);
    endtask
    // pin low for two edges, then a rise; capture lands two edges later
    task power_up(input logic [2:0] m, input logic [1:0] a);
        @(negedge clk_sys);
        chip_power_enable_pin = 0; mode_strap_code = m; address_strap_input = a;
        repeat (2) @(negedge clk_sys);
        chip_power_enable_pin = 1;
        repeat (4) @(negedge clk_sys);
    endtask
    // count driven edges over 256 cycles; tolerance of one edge for phase
    task ratio(input logic [7:0] a, input logic [7:0] b, input int n);
        wr(`SMC_OFS_RATIO_A, a);
        wr(`SMC_OFS_RATIO_B, b);
        cnt_clr = 1;
        repeat (4) @(negedge clk_sys);
        cnt_clr = 0;
        repeat (256) @(negedge clk_sys);
        chk(16'(edge_cnt + 16'h1 >= 16'(n) && edge_cnt <= 16'(n + 1)), 16'h1);
    endtask
    initial
    begin
        #50000;
        err_total++;
        finish_test();
    end
    initial
    begin
        repeat (3) @(negedge clk_sys);
        rstn = 1;
        chk({mode_q, dev_addr_q, clkout_oe_n_q}, {3'h0, 7'h18, 1'b1});
        rd(`SMC_OFS_RATIO_A, `SMC_RST_RATIO_A);
        rd(`SMC_OFS_RATIO_B, `SMC_RST_RATIO_B);
        rd(`SMC_OFS_OSC_CFG, `SMC_RST_OSC_CFG);
        wr(`SMC_OFS_OSC_CFG, 8'h01);
        foreach (rows[i])
        begin
            power_up(rows[i].st, rows[i].ix);
            chk({mode_q, dev_addr_q, io_3v3_q}, {rows[i].md, rows[i].ad, rows[i].io});
            chk({clkout_oe_n_q, low_freq_12bit_raw_ok_q}, {rows[i].oe, rows[i].lf});
            chk({ref_from_back_q, ref_from_ext_q, ref_from_always_on_q},
                {rows[i].md == 3'h0, rows[i].md == 3'h2 || rows[i].md == 3'h5, rows[i].md == 3'h3});
            chk({ten_bit_raw_ok_q, high_freq_12bit_raw_ok_q}, 2'h3);
            rd(`SMC_OFS_MODE_SEL, {5'h0, rows[i].md});
        end
        // strap moves while running: the captured mode must hold
        mode_strap_code = 3'h2;
        repeat (4) @(negedge clk_sys);
        chk(mode_q, 3'h5);
        wr(`SMC_OFS_MODE_SEL, 8'h02);
        chk(mode_q, 3'h5);
        wr(`SMC_OFS_MODE_SEL, 8'h13);
        chk(mode_q, 3'h5);
        wr(`SMC_OFS_MODE_SEL, 8'h13);
        // internal clocking: software raises the oscillator rate and drops clock-out enable
        wr(`SMC_OFS_OSC_CFG, 8'h08);
        repeat (2) @(negedge clk_sys);
        chk({mode_q, clkout_oe_n_q, ref_from_always_on_q}, {3'h3, 1'b1, 1'b1});
        chk(internal_osc_rate_select_q, 1'b1);
        rd(`SMC_OFS_MODE_SEL, 8'h13);
        wr(`SMC_OFS_OSC_CFG, 8'h01);
        wr(`SMC_OFS_MODE_SEL, 8'h10);
        repeat (2) @(negedge clk_sys);
        chk({mode_q, clkout_oe_n_q, internal_osc_rate_select_q}, {3'h0, 1'b0, 1'b0});
        // dividers 4, 8 and 16, an odd denominator, and a stopped generator
        ratio(8'h04, 8'h02, 32);
        ratio(8'h04, 8'h04, 16);
        ratio(8'h05, 8'h02, 16);
        ratio(8'h06, 8'h02, 8);
        ratio(8'h04, 8'h03, 21);
        ratio(8'h00, 8'h01, 0);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        // second reset in mid-run clears mode and register values
        rstn = 0;
        repeat (3) @(negedge clk_sys);
        chk({mode_q, dev_addr_q, clkout_oe_n_q}, {3'h0, 7'h18, 1'b1});
        rstn = 1;
        rd(`SMC_OFS_RATIO_A, `SMC_RST_RATIO_A);
        // power pin stayed high through reset: no edge, so the moved straps are not taken
        chk({mode_q, dev_addr_q, clkout_oe_n_q}, {3'h0, 7'h18, 1'b1});
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
